/* File: hw/gpmc_defs.vh */
// register offsets, field positions, reset values and timing counts for the pin and bus setup block
`ifndef GPMC_DEFS_VH
`define GPMC_DEFS_VH

// register offsets
`define GPMC_PIN_SETUP_ADDR 8'h0E
`define GPMC_MASTER_SET_ADDR 8'h0F

// pin pair setup field positions (pin two low nibble, pin three high nibble)
`define GPMC_EN_BIT 0
`define GPMC_DIR_BIT 1
`define GPMC_REM_BIT 2
`define GPMC_VAL_BIT 3
`define GPMC_PIN_SETUP_RESET 8'h35

// master settings field positions
`define GPMC_WD_DISABLE_BIT 0
`define GPMC_WD_FAST_BIT 1
`define GPMC_LOCK_BIT 2
`define GPMC_DELAY_LO 3
`define GPMC_DELAY_HI 4
`define GPMC_MASTER_WMASK 8'h1F
`define GPMC_MASTER_SET_RESET 8'h00

// timing, clock 250 MHz
`define GPMC_CLK_MHZ 250
`define GPMC_DELAY_BASE_NS 10'h15E
`define GPMC_DELAY_STEP_NS 10'h032
`define GPMC_WD_FAST_US 50
`define GPMC_WD_SLOW_MS 1000
`define GPMC_WD_FAST_CYC (`GPMC_WD_FAST_US * `GPMC_CLK_MHZ)
`define GPMC_WD_SLOW_CYC (`GPMC_WD_SLOW_MS * 1000 * `GPMC_CLK_MHZ)
`define GPMC_RECOVER_PULSES 9
// index of the last of the eighteen scl toggles that make the nine pulses
`define GPMC_RECOVER_LAST_EDGE 5'h11
`define GPMC_SCL_HALF_CYC 1250

`endif

/* File: hw/gpmc_watchdog.v */
// i2c bus watchdog: free-bus detection and nine-pulse hung-bus recovery
`timescale 1ns/10ps
`include "gpmc_defs.vh"

module gpmc_watchdog
#(
    parameter FAST_CYC = `GPMC_WD_FAST_CYC,
    parameter SLOW_CYC = `GPMC_WD_SLOW_CYC,
    parameter HALF_CYC = `GPMC_SCL_HALF_CYC
)
(
    // clock and reset
    input wire clk,
    input wire reset,
    // settings
    input wire disable_wd,
    input wire fast,
    // bus sampling
    input wire scl_in,
    input wire sda_in,
    // results
    output reg bus_free,
    output reg recover_active,
    output reg scl_drive_low
);

    localparam ST_WATCH = 1'b0;
    localparam ST_RECOVER = 1'b1;

    reg state;
    reg [31:0] idle_count;
    reg [31:0] half_count;
    reg [4:0] edges;
    reg last_scl;
    reg last_sda;
    wire activity;
    wire [31:0] limit;

    assign activity = (scl_in != last_scl) || (sda_in != last_sda);
    assign limit = fast ? FAST_CYC : SLOW_CYC; // [R07]

    // idle timer, then either declare free or clock the bus out
    always @(posedge clk)
    begin
        if (reset)
        begin
            state <= ST_WATCH;
            idle_count <= 32'h00000000;
            half_count <= 32'h00000000;
            edges <= 5'h00;
            last_scl <= 1'b1;
            last_sda <= 1'b1;
            bus_free <= 1'b0;
            recover_active <= 1'b0;
            scl_drive_low <= 1'b0;
        end
        else
        begin
            last_scl <= scl_in;
            last_sda <= sda_in;
            case (state)
                ST_WATCH:
                begin
                    scl_drive_low <= 1'b0;
                    recover_active <= 1'b0;
                    if (disable_wd || activity) // [R10]
                    begin
                        idle_count <= 32'h00000000;
                        bus_free <= 1'b0;
                    end
                    else if (idle_count + 32'h00000001 >= limit)
                    begin
                        idle_count <= 32'h00000000;
                        if (sda_in)
                            bus_free <= 1'b1; // [R08]
                        else
                        begin
                            state <= ST_RECOVER; // [R09]
                            recover_active <= 1'b1;
                            edges <= 5'h00;
                            half_count <= 32'h00000000;
                        end
                    end
                    else
                        idle_count <= idle_count + 32'h00000001;
                end
                ST_RECOVER:
                begin
                    // nine low-high pulses, two half periods each
                    if (disable_wd)
                    begin
                        state <= ST_WATCH;
                        scl_drive_low <= 1'b0;
                        recover_active <= 1'b0;
                    end
                    else if (half_count + 32'h00000001 >= HALF_CYC)
                    begin
                        half_count <= 32'h00000000;
                        scl_drive_low <= ~scl_drive_low;
                        if (edges == `GPMC_RECOVER_LAST_EDGE)
                        begin
                            state <= ST_WATCH; // [R09]
                            scl_drive_low <= 1'b0;
                            recover_active <= 1'b0;
                        end
                        edges <= edges + 5'h01;
                    end
                    else
                        half_count <= half_count + 32'h00000001;
                end
                default:
                    state <= ST_WATCH;
            endcase
        end
    end

endmodule

/* File: hw/gpmc_top.v */
// pin pair two/three setup and serial bus master settings registers with pin and bus logic
// What this block does
// R01 - enabled local output drives written value
// R02 - remote bit drives pin from remote value
// R03 - enable 1 drives, direction 1 input unless the remote bit is set
// R04 - delay code adds 50 ns steps from 350
// R05 - lock rejects remote writes to local registers
// R06 - lock leaves forwarded remote slave access alone
// R07 - watchdog about 50 us fast, 1 s slow
// R08 - sda high idle means bus free
// R09 - sda low idle gives nine scl pulses
// R10 - disable bit stops the watchdog entirely
// R11 - reserved master settings bits read zero
`timescale 1ns/10ps
`include "gpmc_defs.vh"

module gpmc_top
#(
    parameter FAST_CYC = `GPMC_WD_FAST_CYC,
    parameter SLOW_CYC = `GPMC_WD_SLOW_CYC,
    parameter HALF_CYC = `GPMC_SCL_HALF_CYC
)
(
    // clock and reset
    input wire clk,
    input wire reset,
    // register access, one cycle strobes
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_remote,
    input wire reg_forward,
    output reg [7:0] reg_rdata,
    output wire reg_rejected,
    output wire forward_allowed,
    // remote values for the two pins
    input wire remote_pin_two,
    input wire remote_pin_three,
    // general pins
    input wire general_pin_two_in,
    output reg general_pin_two_out,
    output reg general_pin_two_oe,
    input wire general_pin_three_in,
    output reg general_pin_three_out,
    output reg general_pin_three_oe,
    output reg [1:0] pin_in_value,
    // serial bus
    input wire scl_in,
    input wire sda_in,
    output wire scl_out,
    output wire scl_oe,
    output reg [9:0] sda_delay_ns,
    output wire bus_free,
    output wire recover_active
);

    // the two registers
    reg [7:0] pin_pair_two_three_setup;
    reg [7:0] serial_bus_master_settings;
    wire local_lock;
    wire write_ok;
    wire scl_low;
    wire [1:0] delay_code;

    // next values of the two registers and of the registered outputs
    reg [7:0] next_pin_setup;
    reg [7:0] next_master_settings;
    reg [7:0] next_rdata;
    reg [1:0] next_pin_two;
    reg [1:0] next_pin_three;
    reg [9:0] next_sda_delay;

    assign local_lock = serial_bus_master_settings[`GPMC_LOCK_BIT];
    // remote writes to own registers are refused while locked
    assign write_ok = reg_write && !(reg_remote && local_lock); // [R05]
    assign reg_rejected = reg_write && reg_remote && local_lock; // [R05]
    // forwarded slave traffic never sees the lock
    assign forward_allowed = reg_forward; // [R06]

    // delay field pulled out once; the arithmetic below stays ten bits wide
    assign delay_code = serial_bus_master_settings[`GPMC_DELAY_HI:`GPMC_DELAY_LO];

    // offset match, shared by the write and the read decode
    function hits;
        input [7:0] addr;
        input [7:0] offset;
        begin
            hits = (addr == offset);
        end
    endfunction

    // drive decision for one pin: oe and value from its nibble
    function [1:0] pin_drive;
        input [3:0] nib;
        input remote_val;
        begin
            if (!nib[`GPMC_EN_BIT])
                pin_drive = 2'b00; // [R03]
            else if (nib[`GPMC_REM_BIT])
                pin_drive = {1'b1, remote_val}; // [R02]
            else if (!nib[`GPMC_DIR_BIT])
                pin_drive = {1'b1, nib[`GPMC_VAL_BIT]}; // [R01]
            else
                pin_drive = 2'b00; // [R03]
        end
    endfunction

    // next register contents; a refused or unmapped write leaves both untouched
    always @*
    begin
        next_pin_setup = pin_pair_two_three_setup;
        next_master_settings = serial_bus_master_settings;
        if (write_ok) // [R05]
        begin
            if (hits(reg_addr, `GPMC_PIN_SETUP_ADDR))
                next_pin_setup = reg_wdata;
            else if (hits(reg_addr, `GPMC_MASTER_SET_ADDR))
                next_master_settings = reg_wdata & `GPMC_MASTER_WMASK; // [R11]
        end
    end

    // register writes take effect on the edge that carries the strobe
    always @(posedge clk)
    begin
        if (reset)
        begin
            pin_pair_two_three_setup <= `GPMC_PIN_SETUP_RESET;
            serial_bus_master_settings <= `GPMC_MASTER_SET_RESET;
        end
        else
        begin
            pin_pair_two_three_setup <= next_pin_setup;
            serial_bus_master_settings <= next_master_settings;
        end
    end

    // read mux; unmapped offsets and reserved settings bits read zero
    always @*
    begin
        if (hits(reg_addr, `GPMC_PIN_SETUP_ADDR))
            next_rdata = pin_pair_two_three_setup;
        else if (hits(reg_addr, `GPMC_MASTER_SET_ADDR))
            next_rdata = serial_bus_master_settings & `GPMC_MASTER_WMASK; // [R11]
        else
            next_rdata = 8'h00;
    end

    // read data registered, valid one edge after the address is presented
    always @(posedge clk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= next_rdata;
    end

    // drive decisions for both pins and the nominal sda delay, settled before the edge
    always @*
    begin
        next_pin_two = pin_drive(pin_pair_two_three_setup[3:0], remote_pin_two);
        next_pin_three = pin_drive(pin_pair_two_three_setup[7:4], remote_pin_three);
        // 350 ns plus 50 ns per code step; a two-bit code cannot overflow ten bits
        next_sda_delay = `GPMC_DELAY_BASE_NS +
            `GPMC_DELAY_STEP_NS * {8'h00, delay_code}; // [R04]
    end

    // pin outputs registered one cycle behind the setup, so a write never glitches a pin
    always @(posedge clk)
    begin
        if (reset)
        begin
            general_pin_two_out <= 1'b0;
            general_pin_two_oe <= 1'b0;
            general_pin_three_out <= 1'b0;
            general_pin_three_oe <= 1'b0;
            pin_in_value <= 2'b00;
            sda_delay_ns <= 10'h000;
        end
        else
        begin
            general_pin_two_oe <= next_pin_two[1]; // [R03]
            general_pin_two_out <= next_pin_two[0]; // [R01] [R02]
            general_pin_three_oe <= next_pin_three[1]; // [R03]
            general_pin_three_out <= next_pin_three[0]; // [R01] [R02]
            pin_in_value <= {general_pin_three_in, general_pin_two_in};
            sda_delay_ns <= next_sda_delay;
        end
    end

    // the watchdog only sees the two setting bits; its spans are counted in clock
    // cycles, so a different core clock must override the cycle count parameters

    gpmc_watchdog #(
        .FAST_CYC(FAST_CYC),
        .SLOW_CYC(SLOW_CYC),
        .HALF_CYC(HALF_CYC)
    ) u_watchdog (
        .clk(clk),
        .reset(reset),
        .disable_wd(serial_bus_master_settings[`GPMC_WD_DISABLE_BIT]), // [R10]
        .fast(serial_bus_master_settings[`GPMC_WD_FAST_BIT]), // [R07]
        .scl_in(scl_in),
        .sda_in(sda_in),
        .bus_free(bus_free),
        .recover_active(recover_active),
        .scl_drive_low(scl_low)
    );

    // open drain scl: only ever pulled low during recovery
    assign scl_out = 1'b0;
    assign scl_oe = scl_low; // [R09]

endmodule

/* File: test/gpmc_top_monitor.sv */
// port checker for the pin and bus setup block
`timescale 1ns/10ps
module gpmc_top_monitor
#(
    parameter FAST_CYC = 20,
    parameter SLOW_CYC = 40
)
(
    // clock, reset and register access
    input wire clk,
    input wire reset,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_rejected,
    input wire reg_forward,
    input wire forward_allowed,
    // pin two
    input wire remote_pin_two,
    input wire general_pin_two_out,
    input wire general_pin_two_oe,
    // serial bus
    input wire scl_in,
    input wire sda_in,
    input wire scl_oe,
    input wire [9:0] sda_delay_ns,
    input wire bus_free,
    input wire recover_active
);
    reg [7:0] pins;
    reg [4:0] mset;
    reg [3:0] pulses;
    reg [31:0] idle;
    wire ok = reg_write && !reg_rejected;
    wire drive = pins[0] && (pins[2] || !pins[1]);
    wire want = pins[2] ? remote_pin_two : pins[3];
    wire [1:0] dcode = mset[4:3];
    wire wd_off = mset[0];
    // shadows of accepted writes; idle span restarts on any bus change
    always @(posedge clk)
    begin
        if (reset)
        begin
            pins <= 8'h35;
            mset <= 5'h00;
        end
        else if (ok && reg_addr == 8'h0E)
            pins <= reg_wdata;
        else if (ok && reg_addr == 8'h0F)
            mset <= reg_wdata[4:0];
        if (reset || !recover_active)
            pulses <= 4'h0;
        else if ($rose(scl_oe))
            pulses <= pulses + 4'h1;
        if (reset || $changed(scl_in) || $changed(sda_in))
            idle <= 32'h0;
        else
            idle <= idle + 32'h1;
    end

    a_forward_passes: assert property (@(posedge clk) disable iff (reset)
        forward_allowed == reg_forward) else $error("forward request blocked");
    a_pin_two_drive: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> general_pin_two_oe == $past(drive)
        && (!general_pin_two_oe || general_pin_two_out == $past(want)))
        else $error("pin two drive wrong");
    a_delay_nominal: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> sda_delay_ns == 10'h15E + 10'h032 * $past(dcode))
        else $error("sda delay wrong");
    a_timeout_span: assert property (@(posedge clk) disable iff (reset)
        $rose(bus_free) || $rose(recover_active) |-> idle + 3 >= (mset[1] ? FAST_CYC : SLOW_CYC))
        else $error("watchdog fired early");
    a_free_needs_high: assert property (@(posedge clk) disable iff (reset)
        $rose(bus_free) |-> $past(sda_in)) else $error("free with sda low");
    a_activity_clears_free: assert property (@(posedge clk) disable iff (reset)
        $changed(sda_in) |=> !bus_free) else $error("free kept after activity");
    a_recover_needs_low: assert property (@(posedge clk) disable iff (reset)
        $rose(recover_active) |-> !$past(sda_in)) else $error("recovery with sda high");
    a_nine_pulses: assert property (@(posedge clk) disable iff (reset)
        $fell(recover_active) && !wd_off |-> pulses == 4'h9) else $error("pulse count wrong");
    a_disable_quiets: assert property (@(posedge clk) disable iff (reset)
        $past(wd_off, 2) && wd_off |-> !bus_free && !recover_active && !scl_oe)
        else $error("watchdog active while off");
endmodule

bind gpmc_top gpmc_top_monitor #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC)) mon (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_rejected(reg_rejected), .reg_forward(reg_forward),
    .forward_allowed(forward_allowed), .remote_pin_two(remote_pin_two),
    .general_pin_two_out(general_pin_two_out), .general_pin_two_oe(general_pin_two_oe),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_delay_ns(sda_delay_ns),
    .bus_free(bus_free), .recover_active(recover_active));

/* File: test/gpmc_far_side.sv */
// far side model: pulled-up serial bus lines
`timescale 1ns/10ps
module gpmc_far_side
(
    // from the block
    input wire scl_oe,
    input wire scl_out,
    // from the bench
    input wire sda_hold_low,
    // levels back to the block
    output wire scl_in,
    output wire sda_in
);
    // open drain: a released line goes to its pull-up level
    assign scl_in = (scl_oe && !scl_out) ? 1'b0 : 1'b1;
    assign sda_in = sda_hold_low ? 1'b0 : 1'b1;
endmodule

/* File: test/gpmc_top_bench.sv */
// bench for the pin and bus setup block
`timescale 1ns/10ps
module gpmc_top_bench;
    reg clk = 1'b0;
    reg reset = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr_s = 1'b0;
    reg remote = 1'b0;
    reg fwd = 1'b0;
    reg rem_two = 1'b1;
    reg rem_three = 1'b1;
    reg sda_low = 1'b0;
    wire [7:0] rdata;
    wire [9:0] delay;
    wire [1:0] pin_in;
    wire rej, fwd_ok, p2_out, p2_oe, p3_out, p3_oe, scl_oe, scl_out, scl_in, sda_in, free, rec;
    integer fails = 0;
    integer num_checks = 0;
    integer pulses = 0;
    integer i, n;

    always #2 clk = ~clk;
    always @(posedge scl_oe) pulses = pulses + 1;

    gpmc_top #(.FAST_CYC(20), .SLOW_CYC(40), .HALF_CYC(3)) dut (
        .clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_remote(remote), .reg_forward(fwd), .reg_rdata(rdata), .reg_rejected(rej),
        .forward_allowed(fwd_ok), .remote_pin_two(rem_two), .remote_pin_three(rem_three),
        .general_pin_two_in(1'b1), .general_pin_two_out(p2_out), .general_pin_two_oe(p2_oe),
        .general_pin_three_in(1'b0), .general_pin_three_out(p3_out),
        .general_pin_three_oe(p3_oe), .pin_in_value(pin_in), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_delay_ns(delay), .bus_free(free),
        .recover_active(rec));
    gpmc_far_side far (.scl_oe(scl_oe), .scl_out(scl_out), .sda_hold_low(sda_low),
        .scl_in(scl_in), .sda_in(sda_in));

    task chk(input [31:0] got, input [31:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // one-cycle write strobe; refusal is visible only inside the strobe
    task wr(input [7:0] a, input [7:0] d, input r, input x);
    begin
        @(negedge clk);
        addr = a;
        wdata = d;
        remote = r;
        wr_s = 1'b1;
        #1 chk(rej, x);
        @(negedge clk);
        wr_s = 1'b0;
        remote = 1'b0;
    end
    endtask

    task rd(input [7:0] a, input [7:0] e);
    begin
        @(negedge clk);
        addr = a;
        @(negedge clk);
        chk(rdata, e);
    end
    endtask

    // out is only meaningful while the pin is driven
    task pin(input [7:0] d, input [3:0] e);
    begin
        wr(8'h0E, d, 1'b0, 1'b0);
        @(negedge clk);
        chk({p3_oe, p3_out & p3_oe, p2_oe, p2_out & p2_oe}, e);
    end
    endtask

    task wt(input [1:0] s, output integer c);
    begin
        c = 0;
        while (c < 300 && !(s == 2'h0 ? free : s == 2'h1 ? rec : !rec))
        begin
            @(negedge clk);
            c = c + 1;
        end
    end
    endtask

    task close_out;
    begin
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    initial
    begin
        #20000;
        fails = fails + 1;
        close_out;
    end

    initial
    begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        rd(8'h0E, 8'h35);
        chk({p3_oe, p2_oe, p2_out}, 3'h3);
        chk(pin_in, 2'h1);
        rd(8'h0F, 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h0F, 8'hFF, 1'b0, 1'b0);
        rd(8'h0F, 8'h1F);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h0F, {3'h0, i[1:0], 3'h1}, 1'b0, 1'b0);
            @(negedge clk);
            chk(delay, 350 + 50 * i);
        end
        pin(8'h09, 4'h3);
        pin(8'h08, 4'h0);
        pin(8'h0B, 4'h0);
        rem_two = 1'b0;
        pin(8'h07, 4'h2);
        pin(8'h90, 4'hC);
        pin(8'h50, 4'hC);
        pin(8'h00, 4'h0);
        // lock against far-side writes, forwarding still open
        wr(8'h0F, 8'h05, 1'b0, 1'b0);
        wr(8'h0E, 8'hFF, 1'b1, 1'b1);
        rd(8'h0E, 8'h00);
        fwd = 1'b1;
        #1 chk(fwd_ok, 1);
        wr(8'h0F, 8'h01, 1'b0, 1'b0);
        fwd = 1'b0;
        wr(8'h0E, 8'h09, 1'b1, 1'b0);
        rd(8'h0E, 8'h09);
        // idle spans: fast then slow, counted from enabling
        wr(8'h0F, 8'h02, 1'b0, 1'b0);
        wt(2'h0, n);
        chk(n > 14 && n < 26, 1);
        wr(8'h0F, 8'h01, 1'b0, 1'b0);
        wr(8'h0F, 8'h00, 1'b0, 1'b0);
        wt(2'h0, n);
        chk(n > 34 && n < 46, 1);
        // hung bus: nine pulses, then abort a second recovery
        wr(8'h0F, 8'h02, 1'b0, 1'b0);
        sda_low = 1'b1;
        wt(2'h1, n);
        chk({rec, free}, 2'h2);
        i = pulses;
        wt(2'h2, n);
        chk(pulses - i, 9);
        wt(2'h1, n);
        chk(rec, 1);
        wr(8'h0F, 8'h03, 1'b0, 1'b0);
        repeat (4) @(negedge clk);
        chk({rec, free, scl_oe}, 3'h0);
        close_out;
    end
endmodule
